// [src/timer_interrupt_control.sv]
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
module timer_interrupt_control (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire timer_irq_pkg::reg_req_s reg_req,
   output logic [7:0] reg_rdata,
   input wire logic machine_tick,
   input wire logic insn_boundary,
   input wire logic svc_return,
   output timer_irq_pkg::core_irq_s core_irq,
   input wire logic ext_a_pin,
   input wire logic ext_b_pin,
   input wire logic count_a_pin,
   input wire logic count_b_pin,
   input wire logic rx_done_flag,
   input wire logic tx_done_flag
);
   import timer_irq_pkg::*;

   state_s st;
   state_s nx;
   logic fall_ext_a;
   logic fall_ext_b;
   logic fall_cnt_a;
   logic fall_cnt_b;
   logic split_a;
   logic inc_a;
   logic inc_b;
   logic inc_a_high;
   logic [16:0] step_a;
   logic [16:0] step_b;
   logic [8:0] ta_high_sum;
   logic ovf_a;
   logic ovf_b;
   logic [4:0] src;
   logic [4:0] cand;
   logic [4:0] high_c;
   logic [4:0] low_c;
   logic [2:0] high_idx;
   logic [2:0] low_idx;
   logic [2:0] win_idx;
   svc_e svc_now;
   logic accept_high;
   logic accept_low;
   logic accept;

   // mode 00 keeps the top three low-byte bits untouched
   function automatic logic [16:0] timer_step(
      input logic [1:0] mode,
      input logic [7:0] lo,
      input logic [7:0] hi,
      input logic inc
   );
      logic [8:0] lo_sum;
      logic [8:0] hi_sum;
      logic [5:0] pre_sum;
      logic [16:0] res;
      lo_sum = {1'b0, lo} + 9'h001;
      hi_sum = {1'b0, hi} + 9'h001;
      pre_sum = {1'b0, lo[4:0]} + 6'h01;
      res = {1'b0, hi, lo};
      if (inc) begin
         unique case (mode)
            MODE_13BIT: begin
               res[4:0] = pre_sum[4:0];
               if (pre_sum[5]) begin
                  res[15:8] = hi_sum[7:0];
                  res[16] = hi_sum[8];
               end
            end
            MODE_16BIT: begin
               res[7:0] = lo_sum[7:0];
               if (lo_sum[8]) begin
                  res[15:8] = hi_sum[7:0];
                  res[16] = hi_sum[8];
               end
            end
            MODE_RELOAD: begin
               res[7:0] = lo_sum[8] ? hi : lo_sum[7:0];
               res[16] = lo_sum[8];
            end
            MODE_SPLIT: begin
               res[7:0] = lo_sum[7:0];
               res[16] = lo_sum[8];
            end
         endcase
      end
      return res;
   endfunction

   function automatic logic [15:0] vector_of(input logic [2:0] idx);
      logic [15:0] v;
      unique case (idx)
         3'h0: v = VEC_EXT_A;
         3'h1: v = VEC_TIMER_A;
         3'h2: v = VEC_EXT_B;
         3'h3: v = VEC_TIMER_B;
         default: v = VEC_SERIAL;
      endcase
      return v;
   endfunction

   function automatic svc_e svc_pop(input svc_e s);
      svc_e r;
      unique case (s)
         svc_both: r = svc_low;
         svc_high: r = svc_none;
         svc_low: r = svc_none;
         svc_none: r = svc_none;
      endcase
      return r;
   endfunction

   always_comb begin
      nx = st;
      nx.take = 1'b0;
      nx.rdata = 8'h00;
      nx.ext_a_last = ext_a_pin;
      nx.ext_b_last = ext_b_pin;
      nx.count_a_last = count_a_pin;
      nx.count_b_last = count_b_pin;
      fall_ext_a = st.ext_a_last & ~ext_a_pin;
      fall_ext_b = st.ext_b_last & ~ext_b_pin;
      fall_cnt_a = st.count_a_last & ~count_a_pin;
      fall_cnt_b = st.count_b_last & ~count_b_pin;
      split_a = st.timer_mode_reg[1:0] == MODE_SPLIT;
      inc_a = st.timer_ctrl_reg[TC_A_RUN]
         && (!st.timer_mode_reg[TM_A_GATE] || ext_a_pin)
         && (st.timer_mode_reg[TM_A_CT] ? fall_cnt_a : machine_tick);
      // timer B holds in mode 11
      inc_b = st.timer_ctrl_reg[TC_B_RUN]
         && (!st.timer_mode_reg[TM_B_GATE] || ext_b_pin)
         && (st.timer_mode_reg[TM_B_CT] ? fall_cnt_b : machine_tick)
         && (st.timer_mode_reg[5:4] != MODE_SPLIT);
      // split high byte on timer B run
      inc_a_high = split_a && st.timer_ctrl_reg[TC_B_RUN] && machine_tick;
      step_a = timer_step(st.timer_mode_reg[1:0], st.timer_a_low_byte,
         st.timer_a_high_byte, inc_a);
      step_b = timer_step(st.timer_mode_reg[5:4], st.timer_b_low_byte,
         st.timer_b_high_byte, inc_b);
      ta_high_sum = {1'b0, st.timer_a_high_byte} + 9'h001;
      ovf_a = step_a[16];
      // timer B cannot flag while its flag is lent to the split high byte
      ovf_b = split_a ? (inc_a_high && ta_high_sum[8]) : step_b[16];
      nx.timer_a_low_byte = step_a[7:0];
      if (split_a) begin
         nx.timer_a_high_byte = inc_a_high ? ta_high_sum[7:0] : st.timer_a_high_byte;
      end else begin
         nx.timer_a_high_byte = step_a[15:8];
      end
      nx.timer_b_low_byte = step_b[7:0];
      nx.timer_b_high_byte = step_b[15:8];

      // serial request is the OR of both done flags
      src = {rx_done_flag | tx_done_flag,
         st.timer_ctrl_reg[TC_B_OVF], st.timer_ctrl_reg[TC_EXT_B_PEND],
         st.timer_ctrl_reg[TC_A_OVF], st.timer_ctrl_reg[TC_EXT_A_PEND]};
      cand = src & st.irq_enable_reg[4:0] & {5{st.irq_enable_reg[BIT_ALL_EN]}};
      high_c = cand & st.irq_priority_reg[4:0];
      low_c = cand & ~st.irq_priority_reg[4:0];
      high_idx = 3'h0;
      low_idx = 3'h0;
      // lowest index wins within a level
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (high_c[i]) begin
            high_idx = 3'(i);
         end
         if (low_c[i]) begin
            low_idx = 3'(i);
         end
      end
      svc_now = svc_return ? svc_pop(st.svc) : st.svc;
      // only a higher level may nest
      accept_high = insn_boundary && (|high_c)
         && (svc_now != svc_high) && (svc_now != svc_both);
      accept_low = insn_boundary && !accept_high && (|low_c)
         && (svc_now == svc_none);
      accept = accept_high || accept_low;
      win_idx = accept_high ? high_idx : low_idx;
      nx.svc = svc_now;
      if (accept_high) begin
         nx.svc = (svc_now == svc_low) ? svc_both : svc_high;
      end else if (accept_low) begin
         nx.svc = svc_low;
      end
      if (accept) begin
         nx.take = 1'b1;
         nx.vector = vector_of(win_idx);
      end

      if (reg_req.wr) begin
         unique case (reg_req.addr)
            ADDR_IRQ_ENABLE: nx.irq_enable_reg = reg_req.wdata & ENABLE_MASK;
            ADDR_IRQ_PRIO: nx.irq_priority_reg = reg_req.wdata & PRIO_MASK;
            ADDR_TIMER_CTRL: nx.timer_ctrl_reg = reg_req.wdata;
            ADDR_TIMER_MODE: nx.timer_mode_reg = reg_req.wdata;
            ADDR_TA_LOW: nx.timer_a_low_byte = reg_req.wdata;
            ADDR_TA_HIGH: nx.timer_a_high_byte = reg_req.wdata;
            ADDR_TB_LOW: nx.timer_b_low_byte = reg_req.wdata;
            ADDR_TB_HIGH: nx.timer_b_high_byte = reg_req.wdata;
            default: nx.irq_enable_reg = nx.irq_enable_reg;
         endcase
      end

      // hardware clear on service, serial flags untouched
      if (accept) begin
         unique case (win_idx)
            3'h0: nx.timer_ctrl_reg[TC_EXT_A_PEND] = 1'b0;
            3'h1: nx.timer_ctrl_reg[TC_A_OVF] = 1'b0;
            3'h2: nx.timer_ctrl_reg[TC_EXT_B_PEND] = 1'b0;
            3'h3: nx.timer_ctrl_reg[TC_B_OVF] = 1'b0;
            default: nx.svc = nx.svc;
         endcase
      end

      // set after clear so an event in the clearing cycle survives
      // overflow sets flag
      if (ovf_a) begin
         nx.timer_ctrl_reg[TC_A_OVF] = 1'b1;
      end
      if (ovf_b) begin
         nx.timer_ctrl_reg[TC_B_OVF] = 1'b1;
      end
      // level mode follows the pin, edge mode latches falls
      if (!st.timer_ctrl_reg[TC_EXT_A_TYPE]) begin
         nx.timer_ctrl_reg[TC_EXT_A_PEND] = ~ext_a_pin;
      end else if (fall_ext_a) begin
         nx.timer_ctrl_reg[TC_EXT_A_PEND] = 1'b1;
      end
      if (!st.timer_ctrl_reg[TC_EXT_B_TYPE]) begin
         nx.timer_ctrl_reg[TC_EXT_B_PEND] = ~ext_b_pin;
      end else if (fall_ext_b) begin
         nx.timer_ctrl_reg[TC_EXT_B_PEND] = 1'b1;
      end

      if (reg_req.rd) begin
         unique case (reg_req.addr)
            ADDR_IRQ_ENABLE: nx.rdata = st.irq_enable_reg & ENABLE_MASK;
            ADDR_IRQ_PRIO: nx.rdata = st.irq_priority_reg & PRIO_MASK;
            ADDR_TIMER_CTRL: nx.rdata = st.timer_ctrl_reg;
            ADDR_TIMER_MODE: nx.rdata = st.timer_mode_reg;
            ADDR_TA_LOW: nx.rdata = st.timer_a_low_byte;
            ADDR_TA_HIGH: nx.rdata = st.timer_a_high_byte;
            ADDR_TB_LOW: nx.rdata = st.timer_b_low_byte;
            ADDR_TB_HIGH: nx.rdata = st.timer_b_high_byte;
            default: nx.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= STATE_RESET;
      end else begin
         st <= nx;
      end
   end

   assign reg_rdata = st.rdata;
   assign core_irq = '{take: st.take, vector: st.vector};

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);

   sequence s_take_timer_a;
      core_irq.take && core_irq.vector == VEC_TIMER_A;
   endsequence

   sequence s_take_serial;
      core_irq.take && core_irq.vector == VEC_SERIAL;
   endsequence

   sequence s_idle_boundary;
      insn_boundary && st.svc == svc_none && !svc_return;
   endsequence

   chk_global_off_block: assert property (
      insn_boundary && !st.irq_enable_reg[BIT_ALL_EN] |=> !core_irq.take)
      else $error("request taken with global enable off");

   chk_source_disable: assert property (
      insn_boundary && !st.irq_enable_reg[SRC_TIMER_A]
      |=> !(core_irq.take && core_irq.vector == VEC_TIMER_A))
      else $error("disabled timer A source taken");

   chk_vector_source: assert property (
      core_irq.take && core_irq.vector == VEC_EXT_B
      |-> $past(st.timer_ctrl_reg[TC_EXT_B_PEND]))
      else $error("ext B vector without pending flag");

   chk_high_over_low: assert property (
      s_idle_boundary ##0 (high_c == 5'h10 && low_c[SRC_EXT_A])
      |=> s_take_serial)
      else $error("high level source did not win");

   chk_no_preempt: assert property (
      insn_boundary && !svc_return && (st.svc == svc_high || st.svc == svc_both)
      |=> !core_irq.take)
      else $error("high service preempted");

   chk_fixed_order: assert property (
      s_idle_boundary ##0 low_c[SRC_EXT_A] && low_c[SRC_TIMER_A] && high_c == 5'h00
      |=> core_irq.take && core_irq.vector == VEC_EXT_A)
      else $error("tie not resolved to ext A");

   chk_edge_pending: assert property (
      st.timer_ctrl_reg[TC_EXT_A_TYPE] && st.ext_a_last && !ext_a_pin
      |=> st.timer_ctrl_reg[TC_EXT_A_PEND])
      else $error("falling edge not latched");

   chk_flag_cleared: assert property (
      s_take_timer_a ##0 !$past(ovf_a) |-> !st.timer_ctrl_reg[TC_A_OVF])
      else $error("timer A flag kept after vectoring");

   chk_run_hold: assert property (
      !st.timer_ctrl_reg[TC_A_RUN] && !(reg_req.wr && reg_req.addr == ADDR_TA_LOW)
      |=> $stable(st.timer_a_low_byte))
      else $error("timer A counted while stopped");

   chk_b_split_hold: assert property (
      st.timer_mode_reg[5:4] == MODE_SPLIT && !reg_req.wr
      |=> $stable({st.timer_b_high_byte, st.timer_b_low_byte}))
      else $error("timer B moved in mode 11");

   chk_reload_byte: assert property (
      st.timer_mode_reg[1:0] == MODE_RELOAD && ovf_a && !reg_req.wr
      |=> st.timer_a_low_byte == $past(st.timer_a_high_byte)
      && st.timer_ctrl_reg[TC_A_OVF])
      else $error("reload or flag missing");

   chk_serial_vector: assert property (
      s_take_serial |-> $past(rx_done_flag || tx_done_flag))
      else $error("serial vector without done flag");
endmodule

// [common/timer_irq_pkg.sv]
package timer_irq_pkg;
   localparam logic [7:0] ADDR_TIMER_CTRL = 8'h88;
   localparam logic [7:0] ADDR_TIMER_MODE = 8'h89;
   localparam logic [7:0] ADDR_TA_LOW = 8'h8A;
   localparam logic [7:0] ADDR_TB_LOW = 8'h8B;
   localparam logic [7:0] ADDR_TA_HIGH = 8'h8C;
   localparam logic [7:0] ADDR_TB_HIGH = 8'h8D;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hA8;
   localparam logic [7:0] ADDR_IRQ_PRIO = 8'hB8;
   localparam logic [7:0] ENABLE_MASK = 8'h9F;
   localparam logic [7:0] PRIO_MASK = 8'h1F;
   localparam int BIT_ALL_EN = 7;
   localparam int NUM_SRC = 5;
   localparam int SRC_EXT_A = 0;
   localparam int SRC_TIMER_A = 1;
   localparam int SRC_EXT_B = 2;
   localparam int SRC_TIMER_B = 3;
   localparam int SRC_SERIAL = 4;
   localparam int TC_EXT_A_TYPE = 0;
   localparam int TC_EXT_A_PEND = 1;
   localparam int TC_EXT_B_TYPE = 2;
   localparam int TC_EXT_B_PEND = 3;
   localparam int TC_A_RUN = 4;
   localparam int TC_A_OVF = 5;
   localparam int TC_B_RUN = 6;
   localparam int TC_B_OVF = 7;
   localparam int TM_A_CT = 2;
   localparam int TM_A_GATE = 3;
   localparam int TM_B_CT = 6;
   localparam int TM_B_GATE = 7;
   localparam logic [1:0] MODE_13BIT = 2'h0;
   localparam logic [1:0] MODE_16BIT = 2'h1;
   localparam logic [1:0] MODE_RELOAD = 2'h2;
   localparam logic [1:0] MODE_SPLIT = 2'h3;
   localparam logic [15:0] VEC_EXT_A = 16'h0003;
   localparam logic [15:0] VEC_TIMER_A = 16'h000B;
   localparam logic [15:0] VEC_EXT_B = 16'h0013;
   localparam logic [15:0] VEC_TIMER_B = 16'h001B;
   localparam logic [15:0] VEC_SERIAL = 16'h0023;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;

   typedef struct packed {
      logic take;
      logic [15:0] vector;
   } core_irq_s;

   typedef enum logic [1:0] {svc_none, svc_low, svc_high, svc_both} svc_e;

   typedef struct packed {
      logic [7:0] irq_enable_reg;
      logic [7:0] irq_priority_reg;
      logic [7:0] timer_ctrl_reg;
      logic [7:0] timer_mode_reg;
      logic [7:0] timer_a_low_byte;
      logic [7:0] timer_a_high_byte;
      logic [7:0] timer_b_low_byte;
      logic [7:0] timer_b_high_byte;
      logic ext_a_last;
      logic ext_b_last;
      logic count_a_last;
      logic count_b_last;
      svc_e svc;
      logic [7:0] rdata;
      logic take;
      logic [15:0] vector;
   } state_s;

   localparam state_s STATE_RESET = state_s'('0);
endpackage

// [verification/core_model.sv]
`timescale 1ns/10ps
module core_model (
   input wire logic sys_clk,
   input wire timer_irq_pkg::core_irq_s core_irq,
   output logic insn_boundary,
   output logic svc_return
);
   import timer_irq_pkg::*;
   int depth = 0;

   initial begin
      insn_boundary = 1'b0;
      svc_return = 1'b0;
   end

   // gap lets the core answer promptly or after a few idle cycles
   task automatic boundary(input int gap, output logic tk, output logic [15:0] vc);
      repeat (gap) @(posedge sys_clk);
      @(posedge sys_clk);
      insn_boundary <= 1'b1;
      @(posedge sys_clk);
      insn_boundary <= 1'b0;
      #1;
      tk = core_irq.take;
      vc = core_irq.vector;
      if (tk === 1'b1) depth++;
   endtask

   task automatic ret();
      if (depth > 0) begin
         @(posedge sys_clk);
         svc_return <= 1'b1;
         @(posedge sys_clk);
         svc_return <= 1'b0;
         depth--;
      end
   endtask
endmodule

// [verification/timer_interrupt_control_tb_top.sv]
`timescale 1ns/10ps
module timer_interrupt_control_tb_top;
   import timer_irq_pkg::*;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   reg_req_s reg_req = '0;
   logic [7:0] reg_rdata;
   logic machine_tick = 1'b0;
   logic insn_boundary;
   logic svc_return;
   core_irq_s core_irq;
   logic ext_a_pin = 1'b1;
   logic ext_b_pin = 1'b1;
   logic count_a_pin = 1'b1;
   logic count_b_pin = 1'b1;
   logic rx_done_flag = 1'b0;
   logic tx_done_flag = 1'b0;
   int n_errors = 0;
   int comparisons = 0;
   int seed = 56479;
   int n;
   logic [7:0] d;
   logic [7:0] h;
   logic [16:0] s;
   logic [7:0] regs [9] = '{ADDR_TIMER_CTRL, ADDR_TIMER_MODE, ADDR_TA_LOW, ADDR_TB_LOW,
      ADDR_TA_HIGH, ADDR_TB_HIGH, ADDR_IRQ_ENABLE, ADDR_IRQ_PRIO, 8'h90};

   always #2 sys_clk = ~sys_clk;

   timer_interrupt_control u_timer_interrupt_control (.sys_clk(sys_clk), .arst_n(arst_n),
      .reg_req(reg_req), .reg_rdata(reg_rdata), .machine_tick(machine_tick),
      .insn_boundary(insn_boundary), .svc_return(svc_return), .core_irq(core_irq),
      .ext_a_pin(ext_a_pin), .ext_b_pin(ext_b_pin), .count_a_pin(count_a_pin),
      .count_b_pin(count_b_pin), .rx_done_flag(rx_done_flag), .tx_done_flag(tx_done_flag));

   core_model u_core_model (.sys_clk(sys_clk), .core_irq(core_irq),
      .insn_boundary(insn_boundary), .svc_return(svc_return));

   function automatic logic [15:0] exp_vec(input int i);
      case (i)
         0: return VEC_EXT_A;
         1: return VEC_TIMER_A;
         2: return VEC_EXT_B;
         3: return VEC_TIMER_B;
         default: return VEC_SERIAL;
      endcase
   endfunction

   // flag that vectoring clears; serial has none
   function automatic logic [7:0] flag_bit(input int i);
      case (i)
         0: return 8'h02;
         1: return 8'h20;
         2: return 8'h08;
         3: return 8'h80;
         default: return 8'h00;
      endcase
   endfunction

   task automatic stop_test();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk_reg(input string name, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic chk_irq(input logic et, input logic [15:0] ev);
      logic tk;
      logic [15:0] vc;
      u_core_model.boundary($unsigned($random(seed)) % 4, tk, vc);
      comparisons++;
      if (tk !== et || (et && vc !== ev)) begin
         n_errors++;
         $display("[ERR] take/vector expected %b/%h seen %b/%h", et, ev, tk, vc);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] dv);
      @(posedge sys_clk);
      reg_req <= '{addr: a, wdata: dv, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      reg_req.wr <= 1'b0;
   endtask

   task automatic rd(input string name, input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      reg_req.rd <= 1'b0;
      #1;
      chk_reg(name, exp, reg_rdata);
   endtask

   task automatic tick(input int k);
      repeat (k) begin
         @(posedge sys_clk);
         machine_tick <= 1'b1;
         @(posedge sys_clk);
         machine_tick <= 1'b0;
      end
   endtask

   task automatic fall_cnt();
      @(posedge sys_clk);
      count_a_pin <= 1'b0;
      count_b_pin <= 1'b0;
      @(posedge sys_clk);
      count_a_pin <= 1'b1;
      count_b_pin <= 1'b1;
   endtask

   task automatic clr_cnt();
      for (int a = 0; a < 4; a++) wr(ADDR_TA_LOW + 8'(a), 8'h00);
   endtask

   // both timers overflow, both pins fall, serial done: timer_ctrl_reg reads FF
   task automatic pend_all();
      wr(ADDR_TIMER_MODE, 8'h11);
      for (int a = 0; a < 4; a++) wr(ADDR_TA_LOW + 8'(a), 8'hFF);
      wr(ADDR_TIMER_CTRL, 8'h55);
      tick(1);
      @(posedge sys_clk);
      ext_a_pin <= 1'b0;
      ext_b_pin <= 1'b0;
      rx_done_flag <= 1'b1;
      @(posedge sys_clk);
      ext_a_pin <= 1'b1;
      ext_b_pin <= 1'b1;
   endtask

   task automatic clean();
      wr(ADDR_IRQ_ENABLE, 8'h00);
      wr(ADDR_IRQ_PRIO, 8'h00);
      wr(ADDR_TIMER_CTRL, 8'h00);
      rx_done_flag <= 1'b0;
   endtask

   initial begin
      repeat (50000) @(posedge sys_clk);
      n_errors++;
      stop_test();
   end

   initial begin
      repeat (20) @(posedge sys_clk);
      arst_n <= 1'b1;
      for (int i = 0; i < 9; i++) rd("reset", regs[i], 8'h00);
      for (int k = 0; k < 6; k++) begin
         d = 8'($random(seed));
         wr(ADDR_IRQ_ENABLE, d & ENABLE_MASK);
         rd("enable", ADDR_IRQ_ENABLE, d & ENABLE_MASK);
         wr(ADDR_IRQ_PRIO, d & PRIO_MASK);
         rd("prio", ADDR_IRQ_PRIO, d & PRIO_MASK);
         wr(ADDR_TIMER_MODE, d);
         rd("mode", ADDR_TIMER_MODE, d);
      end
      clean();
      for (int i = 0; i < NUM_SRC; i++) begin
         pend_all();
         wr(ADDR_IRQ_ENABLE, 8'h80 | (8'h01 << i));
         chk_irq(1'b1, exp_vec(i));
         rd("timer_ctrl_reg", ADDR_TIMER_CTRL, 8'hFF & ~flag_bit(i));
         u_core_model.ret();
         if (i == SRC_SERIAL) chk_irq(1'b1, VEC_SERIAL);
         u_core_model.ret();
         clean();
      end
      pend_all();
      wr(ADDR_IRQ_ENABLE, 8'h1F);
      chk_irq(1'b0, 16'h0000);
      rd("timer_ctrl_reg", ADDR_TIMER_CTRL, 8'hFF);
      wr(ADDR_IRQ_ENABLE, 8'h9F);
      for (int i = 0; i < NUM_SRC; i++) begin
         chk_irq(1'b1, exp_vec(i));
         u_core_model.ret();
      end
      clean();
      pend_all();
      wr(ADDR_IRQ_ENABLE, 8'h83);
      chk_irq(1'b1, VEC_EXT_A);
      chk_irq(1'b0, 16'h0000);
      wr(ADDR_IRQ_PRIO, 8'h02);
      chk_irq(1'b1, VEC_TIMER_A);
      wr(ADDR_IRQ_PRIO, 8'h06);
      wr(ADDR_IRQ_ENABLE, 8'h87);
      chk_irq(1'b0, 16'h0000);
      u_core_model.ret();
      chk_irq(1'b1, VEC_EXT_B);
      u_core_model.ret();
      u_core_model.ret();
      clean();
      // serial raised by the transmit flag alone, at high level over a low ext A
      pend_all();
      rx_done_flag <= 1'b0;
      tx_done_flag <= 1'b1;
      wr(ADDR_IRQ_PRIO, 8'h10);
      wr(ADDR_IRQ_ENABLE, 8'h91);
      chk_irq(1'b1, VEC_SERIAL);
      chk_irq(1'b0, 16'h0000);
      u_core_model.ret();
      chk_irq(1'b1, VEC_SERIAL);
      u_core_model.ret();
      tx_done_flag <= 1'b0;
      clean();
      @(posedge sys_clk);
      ext_a_pin <= 1'b0;
      rd("level", ADDR_TIMER_CTRL, 8'h02);
      @(posedge sys_clk);
      ext_a_pin <= 1'b1;
      ext_b_pin <= 1'b0;
      rd("level", ADDR_TIMER_CTRL, 8'h08);
      @(posedge sys_clk);
      ext_b_pin <= 1'b1;
      rd("level", ADDR_TIMER_CTRL, 8'h00);
      wr(ADDR_TIMER_MODE, 8'h01);
      for (int k = 0; k < 5; k++) begin
         d = (k == 0) ? 8'hFE : 8'($random(seed));
         h = (k == 0) ? 8'hFF : 8'($random(seed));
         n = 1 + $unsigned($random(seed)) % 8;
         s = {1'b0, h, d} + 17'(n);
         wr(ADDR_TA_LOW, d);
         wr(ADDR_TA_HIGH, h);
         wr(ADDR_TIMER_CTRL, 8'h10);
         tick(n);
         rd("a low", ADDR_TA_LOW, s[7:0]);
         rd("a high", ADDR_TA_HIGH, s[15:8]);
         rd("timer_ctrl_reg", ADDR_TIMER_CTRL, {2'b00, s[16], 5'h10});
      end
      wr(ADDR_TIMER_CTRL, 8'h00);
      tick(3);
      rd("stopped", ADDR_TA_LOW, s[7:0]);
      wr(ADDR_TIMER_MODE, 8'h02);
      h = 8'($random(seed)) & 8'h7F;
      wr(ADDR_TA_HIGH, h);
      wr(ADDR_TA_LOW, 8'hFF);
      wr(ADDR_TIMER_CTRL, 8'h10);
      tick(1);
      rd("reload", ADDR_TA_LOW, h);
      rd("reload hi", ADDR_TA_HIGH, h);
      rd("timer_ctrl_reg", ADDR_TIMER_CTRL, 8'h30);
      tick(3);
      rd("reload", ADDR_TA_LOW, h + 8'h03);
      wr(ADDR_TIMER_MODE, 8'h00);
      wr(ADDR_TA_LOW, 8'hFF);
      wr(ADDR_TA_HIGH, 8'h00);
      tick(1);
      rd("13 low", ADDR_TA_LOW, 8'hE0);
      rd("13 high", ADDR_TA_HIGH, 8'h01);
      clr_cnt();
      wr(ADDR_TIMER_MODE, 8'h55);
      wr(ADDR_TIMER_CTRL, 8'h50);
      tick(2);
      fall_cnt();
      fall_cnt();
      rd("a count", ADDR_TA_LOW, 8'h02);
      rd("b count", ADDR_TB_LOW, 8'h02);
      clr_cnt();
      wr(ADDR_TIMER_MODE, 8'h99);
      @(posedge sys_clk);
      ext_a_pin <= 1'b0;
      ext_b_pin <= 1'b0;
      tick(2);
      @(posedge sys_clk);
      ext_a_pin <= 1'b1;
      ext_b_pin <= 1'b1;
      tick(3);
      rd("a gate", ADDR_TA_LOW, 8'h03);
      rd("b gate", ADDR_TB_LOW, 8'h03);
      clr_cnt();
      wr(ADDR_TB_LOW, 8'h12);
      wr(ADDR_TIMER_MODE, 8'h33);
      tick(2);
      rd("split lo", ADDR_TA_LOW, 8'h02);
      rd("split hi", ADDR_TA_HIGH, 8'h02);
      rd("b hold", ADDR_TB_LOW, 8'h12);
      wr(ADDR_TA_HIGH, 8'hFF);
      wr(ADDR_TIMER_CTRL, 8'h40);
      tick(1);
      rd("split lo", ADDR_TA_LOW, 8'h02);
      rd("split hi", ADDR_TA_HIGH, 8'h00);
      rd("timer_ctrl_reg", ADDR_TIMER_CTRL, 8'hC0);
      stop_test();
   end
endmodule
